// >>> src/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// Register byte offsets on the APB.
`define SSP_OFS_CONFIG      8'h00
`define SSP_OFS_OPERATION   8'h04
`define SSP_OFS_RX_BUFFER   8'h08
`define SSP_OFS_SHIFT_DATA  8'h0C
`define SSP_OFS_PRIORITY    8'h10

// Fields of the port configuration register.
`define SSP_CFG_LEN_LSB     0
`define SSP_CFG_LEN_MSB     2
`define SSP_CFG_RATE_LSB    3
`define SSP_CFG_RATE_MSB    5
`define SSP_CFG_POLARITY    6
`define SSP_CFG_SOFT_RESET  7

// Fields of the port operation register.
`define SSP_OP_IRQ_ENABLE   0
`define SSP_OP_PERMIT       1
`define SSP_OP_MASTER       2
`define SSP_OP_DONE         6
`define SSP_OP_OVERRUN      7

// Field of the port priority register.
`define SSP_PRI_LOW         6

// Reset values; the port comes out of reset held in soft reset.
`define SSP_RST_CONFIG      8'h80
`define SSP_RST_OPERATION   3'h0
`define SSP_RST_PRIORITY    1'h0

`endif

// >>> src/ssp_port.v
// Operation
// - Soft reset freezes shift logic until released.
// - Length field bits 0-2 gives code plus one.
// - Transmit data leaves most significant bit first.
// - Received bits enter at LSB, shift upward.
// - Master clock is system clock over 2^(code+1).
// - Master write to shift data starts transfer.
// - Slave takes clock from pin, ignores rate.
// - Polarity bit six picks the latching edge.
// - Completion sets done flag; enable at bit 0.
// - Done flag read-only, cleared by buffer read.
// - Interrupt requested while flag and enable set.
// - Priority bit six routes request high/low.
// - Overrun flag when unread character is replaced.
// - Permit low stops data drive, receives on.
// - No parity or error detection in hardware.
// - Master shifts out and captures simultaneously.
// - Each finished character copied to receive buffer.
// - Slave shifts on received clock, clock is input.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.vh"

module ssp_port (
    // Clock and synchronous reset.
    input  wire        ref_clk,
    input  wire        reset,
    // APB slave port.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    // Interrupt requests, one per priority level.
    output reg         irq_high_ff,
    output reg         irq_low_ff,
    // Serial clock pin as input, output and enable.
    input  wire        serial_clock_pin_in,
    output reg         serial_clock_pin_out_ff,
    output reg         serial_clock_pin_oe_ff,
    // Master-out data pin as input, output and enable.
    input  wire        master_out_data_pin_in,
    output reg         master_out_data_pin_out_ff,
    output reg         master_out_data_pin_oe_ff,
    // Slave-out data pin as input, output and enable.
    input  wire        slave_out_data_pin_in,
    output reg         slave_out_data_pin_out_ff,
    output reg         slave_out_data_pin_oe_ff
);

    // Software-visible registers.
    reg  [7:0] port_config_reg_ff;     // Length, rate, polarity, soft reset.
    reg  [2:0] op_ctrl_ff;             // Irq enable, permit, master.
    reg        done_flag_ff;           // Character completed.
    reg        rx_overrun_flag_ff;     // Unread character was replaced.
    reg        port_priority_ff;       // One routes the request low.
    reg  [7:0] receive_buffer_reg_ff;  // Last finished character.
    reg  [7:0] shift_data_reg_ff;      // Shift register proper.

    // Shift engine state.
    reg        active_ff;              // Master transfer in progress.
    reg  [2:0] bit_cnt_ff;             // Bits finished in this character.
    reg        rx_bit_ff;              // Bit caught on the latching edge.
    reg  [7:0] div_cnt_ff;             // Master half-period counter.
    reg        sclk_level_ff;          // Master clock level being driven.

    // Slave clock synchroniser and edge history.
    reg        sclk_sync1_ff;
    reg        sclk_sync2_ff;
    reg        sclk_prev_ff;

    // Next-state values.
    reg  [7:0] nxt_shift_data_reg_ff;
    reg  [2:0] nxt_bit_cnt_ff;
    reg        nxt_active_ff;
    reg        nxt_rx_bit_ff;
    reg  [7:0] nxt_div_cnt_ff;
    reg        nxt_sclk_level_ff;
    reg        char_done;              // Pulse when a character ends.
    reg  [7:0] rd_mux;                 // Read data selected by address.
    reg        addr_hit;               // Address maps to a register.

    // Decoded control fields.
    wire       soft_rst   = port_config_reg_ff[`SSP_CFG_SOFT_RESET];
    wire       polarity   = port_config_reg_ff[`SSP_CFG_POLARITY];
    wire [2:0] len_code   =
        port_config_reg_ff[`SSP_CFG_LEN_MSB:`SSP_CFG_LEN_LSB];
    wire [2:0] rate_code  =
        port_config_reg_ff[`SSP_CFG_RATE_MSB:`SSP_CFG_RATE_LSB];
    wire       irq_en     = op_ctrl_ff[`SSP_OP_IRQ_ENABLE];
    wire       permit     = op_ctrl_ff[`SSP_OP_PERMIT];
    wire       master     = op_ctrl_ff[`SSP_OP_MASTER];

    // APB strobes; the write or read side effect lands on the access edge.
    wire       acc     = psel & penable & pready_ff;
    wire       wr_en   = acc & pwrite;
    wire       rd_en   = acc & ~pwrite;
    wire       wr_data = wr_en && (paddr == `SSP_OFS_SHIFT_DATA);
    wire       rd_buf  = rd_en && (paddr == `SSP_OFS_RX_BUFFER);

    // Half a serial clock period in system clocks: 2^code.
    function [7:0] half_period;
        input [2:0] code;
        begin
            half_period = 8'h01 << code;
        end
    endfunction

    // Slave clock edges, judged only from the second stage onward.
    wire       s_rise  = sclk_sync2_ff & ~sclk_prev_ff;
    wire       s_fall  = ~sclk_sync2_ff & sclk_prev_ff;
    // Polarity zero latches on the rising edge, one on the falling.
    wire       s_latch = polarity ? s_fall : s_rise;
    wire       s_shift = polarity ? s_rise : s_fall;

    // Master edges: a toggle away from idle latches, back to idle shifts.
    // The divider ends one system clock before each half period.
    wire       m_tick  = active_ff &&
                         (div_cnt_ff == half_period(rate_code) - 8'h01);
    wire       m_latch = m_tick & (sclk_level_ff == polarity);
    wire       m_shift = m_tick & (sclk_level_ff != polarity);

    // Shift engine; no parity or check bits are ever added.
    always @* begin
        nxt_shift_data_reg_ff = shift_data_reg_ff;
        nxt_bit_cnt_ff        = bit_cnt_ff;
        nxt_active_ff         = active_ff;
        nxt_rx_bit_ff         = rx_bit_ff;
        nxt_div_cnt_ff        = div_cnt_ff;
        nxt_sclk_level_ff     = sclk_level_ff;
        char_done             = 1'b0;
        if (soft_rst) begin
            // Everything frozen and idle while held.
            nxt_active_ff     = 1'b0;
            nxt_bit_cnt_ff    = 3'h0;
            nxt_div_cnt_ff    = 8'h00;
            nxt_sclk_level_ff = polarity;
        end else if (wr_data) begin
            // Software load; in master mode this starts a character.
            nxt_shift_data_reg_ff = pwdata[7:0];
            nxt_bit_cnt_ff        = 3'h0;
            nxt_active_ff         = master;
            nxt_div_cnt_ff        = 8'h00;
            nxt_sclk_level_ff     = polarity;
        end else if (master) begin
            // Master: divider runs only during a transfer.
            if (active_ff) begin
                nxt_div_cnt_ff = m_tick ? 8'h00 : div_cnt_ff + 8'h01;
            end
            if (m_tick) begin
                nxt_sclk_level_ff = ~sclk_level_ff;
            end
            if (m_latch) begin
                nxt_rx_bit_ff = slave_out_data_pin_in;
            end
            if (m_shift) begin
                // New bit enters at the bottom, MSB moves out.
                nxt_shift_data_reg_ff = {shift_data_reg_ff[6:0], rx_bit_ff};
                nxt_bit_cnt_ff        = bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == len_code) begin
                    char_done      = 1'b1;
                    nxt_active_ff  = 1'b0;
                    nxt_bit_cnt_ff = 3'h0;
                end
            end
        end else begin
            // Slave: clock comes from the pin, rate unused.
            nxt_active_ff = 1'b0;
            if (s_latch) begin
                nxt_rx_bit_ff = master_out_data_pin_in;
            end
            if (s_shift) begin
                nxt_shift_data_reg_ff = {shift_data_reg_ff[6:0], rx_bit_ff};
                nxt_bit_cnt_ff        = bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == len_code) begin
                    char_done      = 1'b1;
                    nxt_bit_cnt_ff = 3'h0;
                end
            end
        end
    end

    // Shift engine registers.
    always @(posedge ref_clk) begin
        if (reset) begin
            shift_data_reg_ff <= 8'h00;
            bit_cnt_ff        <= 3'h0;
            active_ff         <= 1'b0;
            rx_bit_ff         <= 1'b0;
            div_cnt_ff        <= 8'h00;
            sclk_level_ff     <= 1'b0;
        end else begin
            shift_data_reg_ff <= nxt_shift_data_reg_ff;
            bit_cnt_ff        <= nxt_bit_cnt_ff;
            active_ff         <= nxt_active_ff;
            rx_bit_ff         <= nxt_rx_bit_ff;
            div_cnt_ff        <= nxt_div_cnt_ff;
            sclk_level_ff     <= nxt_sclk_level_ff;
        end
    end

    // Two-stage synchroniser for the slave clock plus an edge history.
    // The slave path relies on the external clock being slow enough.
    always @(posedge ref_clk) begin
        if (reset) begin
            sclk_sync1_ff <= 1'b0;
            sclk_sync2_ff <= 1'b0;
            sclk_prev_ff  <= 1'b0;
        end else begin
            sclk_sync1_ff <= serial_clock_pin_in;
            sclk_sync2_ff <= sclk_sync1_ff;
            sclk_prev_ff  <= sclk_sync2_ff;
        end
    end

    // Receive buffer, done flag and overrun flag.
    // A completion in the same cycle as a clearing read wins.
    always @(posedge ref_clk) begin
        if (reset) begin
            receive_buffer_reg_ff <= 8'h00;
            done_flag_ff          <= 1'b0;
            rx_overrun_flag_ff    <= 1'b0;
        end else begin
            if (char_done) begin
                // Whole character copied out for software.
                receive_buffer_reg_ff <= nxt_shift_data_reg_ff;
            end
            if (soft_rst) begin
                done_flag_ff       <= 1'b0;
                rx_overrun_flag_ff <= 1'b0;
            end else begin
                // Set regardless of the interrupt enable.
                done_flag_ff <= char_done | (done_flag_ff & ~rd_buf);
                // Unread character overwritten means lost data.
                rx_overrun_flag_ff <= (char_done & done_flag_ff & ~rd_buf) |
                                      (rx_overrun_flag_ff & ~rd_buf);
            end
        end
    end

    // Control registers written over the APB.
    always @(posedge ref_clk) begin
        if (reset) begin
            port_config_reg_ff <= `SSP_RST_CONFIG;
            op_ctrl_ff         <= `SSP_RST_OPERATION;
            port_priority_ff   <= `SSP_RST_PRIORITY;
        end else if (wr_en) begin
            case (paddr)
                `SSP_OFS_CONFIG: begin
                    port_config_reg_ff <= pwdata[7:0];
                end
                `SSP_OFS_OPERATION: begin
                    // Flags at bits 6 and 7 are read-only.
                    op_ctrl_ff <= pwdata[2:0];
                end
                `SSP_OFS_PRIORITY: begin
                    port_priority_ff <= pwdata[`SSP_PRI_LOW];
                end
                default: begin
                    // Other addresses store nothing here; a shift data write is loaded by the shift engine.
                end
            endcase
        end
    end

    // Read data and address decode.
    always @* begin
        rd_mux   = 8'h00;
        addr_hit = 1'b1;
        case (paddr)
            `SSP_OFS_CONFIG:     rd_mux = port_config_reg_ff;
            `SSP_OFS_OPERATION:  rd_mux = {rx_overrun_flag_ff, done_flag_ff,
                                           3'h0, op_ctrl_ff};
            `SSP_OFS_RX_BUFFER:  rd_mux = receive_buffer_reg_ff;
            `SSP_OFS_SHIFT_DATA: rd_mux = shift_data_reg_ff;
            `SSP_OFS_PRIORITY:   rd_mux = {1'b0, port_priority_ff, 6'h00};
            default:             addr_hit = 1'b0;
        endcase
    end

    // APB answer: one wait-free access phase after each setup cycle.
    always @(posedge ref_clk) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & ~penable & ~pready_ff;
            prdata_ff  <= {24'h00_0000, rd_mux};
            pslverr_ff <= psel & ~penable & ~pready_ff & ~addr_hit;
        end
    end

    // Interrupt request held for as long as flag and enable stand.
    always @(posedge ref_clk) begin
        if (reset) begin
            irq_high_ff <= 1'b0;
            irq_low_ff  <= 1'b0;
        end else begin
            irq_high_ff <= done_flag_ff & irq_en & ~port_priority_ff;
            irq_low_ff  <= done_flag_ff & irq_en & port_priority_ff;
        end
    end

    // Pin drivers; data pins follow the next shift MSB to avoid lag.
    always @(posedge ref_clk) begin
        if (reset) begin
            serial_clock_pin_out_ff    <= 1'b0;
            serial_clock_pin_oe_ff     <= 1'b0;
            master_out_data_pin_out_ff <= 1'b0;
            master_out_data_pin_oe_ff  <= 1'b0;
            slave_out_data_pin_out_ff  <= 1'b0;
            slave_out_data_pin_oe_ff   <= 1'b0;
        end else begin
            // Clock pin is driven only in master mode.
            serial_clock_pin_out_ff    <= nxt_sclk_level_ff;
            serial_clock_pin_oe_ff     <= master;
            master_out_data_pin_out_ff <= nxt_shift_data_reg_ff[7];
            slave_out_data_pin_out_ff  <= nxt_shift_data_reg_ff[7];
            // Permit low: no data drive, reception continues.
            master_out_data_pin_oe_ff  <= master & permit;
            slave_out_data_pin_oe_ff   <= ~master & permit;
        end
    end

endmodule // ssp_port
`default_nettype wire

// >>> bench/ssp_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Pin watcher; it shadows the control bits it needs from APB writes.
module ssp_chk (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        reset,
    // APB slave side.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready_ff,
    input wire logic        pslverr_ff,
    // Requests and pins.
    input wire logic        irq_high_ff,
    input wire logic        irq_low_ff,
    input wire logic        serial_clock_pin_out_ff,
    input wire logic        serial_clock_pin_oe_ff,
    input wire logic        master_out_data_pin_oe_ff,
    input wire logic        slave_out_data_pin_oe_ff
);
    logic [7:0]  cfg_ff; // Configuration shadow.
    logic [2:0]  op_ff;  // Master, permit and enable shadow.
    logic        pri_ff; // Low priority shadow.
    logic [15:0] gap_ff; // Cycles since the clock pin last moved.
    wire wr  = psel && penable && pwrite && pready_ff;
    wire hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    // Shadows follow each write on the edge where it takes effect.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_ff <= 8'h80;
            op_ff  <= 3'h0;
            pri_ff <= 1'b0;
            gap_ff <= 16'hffff;
        end else begin
            if (wr && paddr == 8'h00) cfg_ff <= pwdata[7:0];
            if (wr && paddr == 8'h04) op_ff <= pwdata[2:0];
            if (wr && paddr == 8'h10) pri_ff <= pwdata[6];
            // A new character sets the spacing count to 16'hffff, so the first clock move is not judged.
            if (wr && paddr == 8'h0C) gap_ff <= 16'hffff;
            else if ($changed(serial_clock_pin_out_ff)) gap_ff <= 16'h0001;
            else if (gap_ff != 16'hffff) gap_ff <= gap_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_ready_zero_wait: assert property (psel && !penable |=> pready_ff)
        else $error("pready late");
    chk_ready_one_pulse: assert property (pready_ff |=> !pready_ff)
        else $error("pready held");
    chk_unmapped_error: assert property (pready_ff |-> pslverr_ff == !hit)
        else $error("pslverr wrong");
    chk_irq_enable_gate: assert property (
        !$past(op_ff[0]) |-> !(irq_high_ff || irq_low_ff))
        else $error("request while disabled");
    chk_irq_prio_route: assert property (
        (irq_high_ff || irq_low_ff) |->
        irq_low_ff == $past(pri_ff) && irq_high_ff != $past(pri_ff))
        else $error("request routed wrong");
    chk_clock_pin_dir: assert property (
        op_ff[2] == $past(op_ff[2]) |-> serial_clock_pin_oe_ff == op_ff[2])
        else $error("clock pin direction");
    chk_data_pin_dir: assert property (
        op_ff[2:1] == $past(op_ff[2:1]) |->
        master_out_data_pin_oe_ff == &op_ff[2:1] &&
        slave_out_data_pin_oe_ff == (op_ff[1] && !op_ff[2]))
        else $error("data pin drive");
    chk_sclk_half_period: assert property (
        serial_clock_pin_oe_ff && !cfg_ff[7] && $stable(cfg_ff) &&
        $changed(serial_clock_pin_out_ff) |->
        gap_ff >= (16'h0001 << cfg_ff[5:3]))
        else $error("clock too fast");
    chk_sclk_idle_frozen: assert property (
        cfg_ff[7] && $stable(cfg_ff) && op_ff[2] |->
        serial_clock_pin_out_ff == cfg_ff[6])
        else $error("clock not idle");
endmodule // ssp_chk
`default_nettype wire

// >>> bench/ssp_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// External slave: offers one character and records what it hears.
module ssp_slave_model (
    // Lines from the port.
    input wire logic  sclk,
    input wire logic  mosi,
    input wire logic  pol,
    // Lines back and bits seen.
    output logic       miso,
    output logic [7:0] got
);
    logic [7:0] tx = 8'h00; // Character still to send.
    initial got = 8'h00;
    // Top bit is always on the line, so the first bit is ready early.
    assign miso = tx[7];
    // Load a new character and forget what was heard.
    task automatic offer(input logic [7:0] v);
        tx = v;
        got = 8'h00;
    endtask
    // Leading edge latches, trailing edge moves on to the next bit.
    always @(sclk) begin
        if (sclk !== pol) begin
            got <= {got[6:0], mosi};
        end else begin
            tx <= {tx[6:0], ~tx[7]};
        end
    end
endmodule // ssp_slave_model
`default_nettype wire

// >>> bench/synchronous_serial_port_test.sv
`timescale 1ns/1ns
`default_nettype none
// Drives the port over APB and checks it against the slave model.
module synchronous_serial_port_test;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    wire  [31:0] prdata_ff;
    wire         pready_ff, pslverr_ff, irq_high_ff, irq_low_ff;
    wire         sck_out, sck_oe, mo_out, mo_oe, so_out, so_oe, miso;
    wire  [7:0]  got_w;                   // Bits the slave heard.
    logic        pol_v = 1'b0;            // Idle level of the clock.
    logic        ext_sck = 1'b0;          // Far master clock, slave mode.
    logic        last_err = 1'b0;         // Error flag of last access.
    logic        sck_q = 1'b0;            // Clock pin one edge ago.
    logic [31:0] q, e;                    // Read data and expectation.
    logic [7:0]  d, p;                    // Sent and offered characters.
    int          err_count = 0, check_count = 0;
    int          tog = 0, cyc = 0, t0 = 0, t1 = 0, n = 8, h = 1;
    // Released lines: clock rests at idle, data shows the inverse.
    // In slave mode the bench makes the clock, the model's bit is the
    // far master's data, and the model hears the slave-out line.
    wire sck_w  = sck_oe ? sck_out : pol_v ^ ext_sck;
    wire so_w   = so_oe ? so_out : ~got_w[0];
    wire mosi_w = mo_oe ? mo_out : sck_oe ? ~got_w[0] : miso;
    ssp_port uut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .irq_high_ff(irq_high_ff),
        .irq_low_ff(irq_low_ff), .serial_clock_pin_in(sck_w),
        .serial_clock_pin_out_ff(sck_out), .serial_clock_pin_oe_ff(sck_oe),
        .master_out_data_pin_in(mosi_w), .master_out_data_pin_out_ff(mo_out),
        .master_out_data_pin_oe_ff(mo_oe), .slave_out_data_pin_in(miso),
        .slave_out_data_pin_out_ff(so_out), .slave_out_data_pin_oe_ff(so_oe));
    ssp_slave_model pm (.sclk(sck_w), .mosi(sck_oe ? mosi_w : so_w),
        .pol(pol_v),
        .miso(miso), .got(got_w));
    initial forever #50 ref_clk = ~ref_clk;
    // Counts clock pin moves and notes the first and last one.
    always @(posedge ref_clk) begin
        if (sck_out !== sck_q) begin
            if (tog == 0) t0 = cyc;
            t1 = cyc;
            tog++;
        end
        sck_q = sck_out;
        cyc++;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; entered just after an edge, read data in q.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [7:0] v);
        int k;
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, v};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            if (k++ == 16) begin
                err_count++;
                print_verdict();
            end
        end while (pready_ff !== 1'b1);
        q        = prdata_ff;
        last_err = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(a, 1'b1, v);
    endtask
    // New settings are made only under soft reset, then released.
    task automatic cfg(input logic [7:0] c);
        pol_v <= c[6];
        wr(8'h00, c | 8'h80);
        wr(8'h00, c);
    endtask
    // Send one character of n bits and poll until it has finished.
    task automatic go(input logic [7:0] v, input logic [7:0] s);
        int k;
        pm.offer(s);
        tog = 0;
        wr(8'h0C, v);
        k = 0;
        q = 32'h0000_0000;
        while (q[6] !== 1'b1 || tog < 2 * n) begin
            if (k++ == 1000) begin
                err_count++;
                print_verdict();
            end
            rd(8'h04);
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(8'h00);
        check(q, 32'h0000_0080);
        rd(8'h04);
        check(q, 32'h0000_0000);
        rd(8'h14);
        check(q, 32'h0000_0000);
        check(32'(last_err), 32'h0000_0001);
        $display("reset values done");
        wr(8'h04, 8'h07);
        wr(8'h10, 8'h00);
        // Every length code, each with rate code seven minus it, polarity alternating.
        for (int i = 0; i < 8; i++) begin
            n = i + 1;
            h = 1 << (7 - i);
            d = 8'h96 + 8'(37 * i);
            p = 8'h5a ^ 8'(17 * i);
            e = 32'((16'(d) << n) | 16'(p >> (8 - n))) & 32'h0000_00ff;
            cfg(8'(i) | 8'((7 - i) << 3) | 8'(i % 2 << 6));
            go(d, p);
            check(tog, 2 * n);
            check(t1 - t0, (2 * n - 1) * h);
            check(got_w & 8'((1 << n) - 1), d >> (8 - n));
            check(32'(irq_high_ff), 32'h0000_0001);
            rd(8'h08);
            check(q, e);
            rd(8'h04);
            check(q, 32'h0000_0007);
            check(32'(irq_high_ff), 32'h0000_0000);
            $display("length %0d done", n);
        end
        // Silent transmitter, low priority, first character unread.
        wr(8'h04, 8'h05);
        wr(8'h10, 8'h40);
        n = 8;
        cfg(8'h07);
        go(8'h12, 8'h34);
        go(8'h56, 8'h9c);
        rd(8'h04);
        check(q, 32'h0000_00c5);
        check(32'(irq_low_ff), 32'h0000_0001);
        check(32'(irq_high_ff), 32'h0000_0000);
        rd(8'h08);
        check(q, 32'h0000_009c);
        rd(8'h04);
        check(q, 32'h0000_0005);
        $display("overrun done");
        // Soft reset clears the flag and keeps the clock still.
        go(8'ha5, 8'h3c);
        wr(8'h00, 8'h87);
        rd(8'h04);
        check(q, 32'h0000_0005);
        tog = 0;
        wr(8'h0C, 8'hff);
        repeat (20) @(posedge ref_clk);
        check(tog, 0);
        wr(8'h04, 8'hc7);
        rd(8'h04);
        check(q, 32'h0000_0007);
        $display("soft reset done");
        // Slave, request disabled: the bench clocks at system/8.
        wr(8'h04, 8'h02);
        cfg(8'h07);
        pm.offer(8'hc3);
        wr(8'h0C, 8'h6b);
        tog = 0;
        repeat (16) begin
            repeat (4) @(posedge ref_clk);
            ext_sck <= ~ext_sck;
        end
        repeat (8) @(posedge ref_clk);
        rd(8'h04);
        check(q, 32'h0000_0042);
        check(32'(irq_high_ff | irq_low_ff), 32'h0000_0000);
        check(tog, 0);
        check(got_w, 8'h6b);
        rd(8'h08);
        check(q, 32'h0000_00c3);
        $display("slave done");
        print_verdict();
    end
endmodule // synchronous_serial_port_test
bind ssp_port ssp_chk chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .irq_high_ff(irq_high_ff), .irq_low_ff(irq_low_ff),
    .serial_clock_pin_out_ff(serial_clock_pin_out_ff),
    .serial_clock_pin_oe_ff(serial_clock_pin_oe_ff),
    .master_out_data_pin_oe_ff(master_out_data_pin_oe_ff),
    .slave_out_data_pin_oe_ff(slave_out_data_pin_oe_ff));
`default_nettype wire
